// File: hdl/msdu_agg_consts.vh
// Operation
// - Aggregate only MSDUs that share one Delivery ID.
// - Never place more MSDUs in one aggregate than the aggregation limit.
// - Frames of an aggregation exchange always use the aggregated frame layout.
// - Send aggregates only to a peer advertising aggregation capability.
// - Start with a data frame: request bit one, B-ACK Request, one stream.
// - Each aggregation instance per stream or peer keeps its own state; here one state set is time-shared by Delivery ID.
// - Recipient declining a request answers with an empty-payload block ack.
// - Recipient accepting answers with limits and marks the request frame received.
// - No block ack after a request: resend the request.
// - Empty-payload block ack: frame delivered, aggregation marked refused.
// - Zero count or size: process ack, then send new or same request.
// - Held MSDUs before the reported sequence are dropped, never resent.
// - Held MSDUs with their window bit set are delivered, never resent.
// - Other held MSDUs are resent next, in increasing sequence order.
// - New aggregate within granted frame count and granted buffer size.
// - Inside one aggregate MSDUs follow increasing sequence and fragment.
// - Aggregate with B-ACK Request gets a payload block ack one SIFS later.
// - Good header but bad frame check still gets a payload block ack.
// - Every payload block ack carries frame count and buffer size limits.
// - Failed subframes not timed out are flagged through sequence and bitmap.
// - Missing-frame timeout releases buffered MSDUs to the client.
`ifndef MSDU_AGG_CONSTS_VH
`define MSDU_AGG_CONSTS_VH
`define A_CTRL     8'h00
`define A_DID      8'h04
`define A_PUSH     8'h08
`define A_STATUS   8'h0C
`define A_GRANT    8'h10
`define A_RXLIM    8'h14
`define A_CMD      8'h18
`define B_EN       0
`define B_PEERCAP  1
`define B_ACCEPT   2
`define B_START    0
`define CTRL_RST   3'h0
`define DID_RST    4'h0
`define RXLIM_RST  24'h000000
`define POL_BACK   2'h2
`define POL_BREQ   2'h3
`define SEQ_HALF   12'h800
`define CLK_NS     20
`define SIFS_NS    2500
`endif

// File: hdl/back_match.v
`timescale 1ns/1ns
`default_nettype none
`include "msdu_agg_consts.vh"
module back_match #(
  parameter BMAP_W = 16
) (
  input  wire [11:0]       seq_i,
  input  wire [11:0]       ack_seq_i,
  input  wire [BMAP_W-1:0] bmap_i,
  output reg               drop_o,
  output reg               acked_o
);
  reg [11:0] off;
  always @*
  begin
    off     = seq_i - ack_seq_i;
    drop_o  = (off >= `SEQ_HALF);
    acked_o = (off < BMAP_W) && bmap_i[off[3:0]];
  end
endmodule // back_match
`default_nettype wire

// File: hdl/msdu_agg_back.v
`timescale 1ns/1ns
`default_nettype none
`include "msdu_agg_consts.vh"
module msdu_agg_back #(
  parameter DEPTH         = 8,
  parameter AW            = 3,
  parameter BMAP_W        = 16,
  parameter AGG_LIMIT     = 8,
  parameter BACK_WAIT_CYC = 5000,
  parameter MISS_TO_CYC   = 50000
) (
  input  wire              clk_i,
  input  wire              rst_i,
  input  wire              cyc_i,
  input  wire              stb_i,
  input  wire              we_i,
  input  wire [7:0]        adr_i,
  input  wire [3:0]        sel_i,
  input  wire [31:0]       dat_i,
  output reg  [31:0]       dat_o,
  output reg               ack_o,
  output reg               tx_start_o,
  output reg               tx_agg_o,
  output reg               tx_areq_o,
  output reg  [1:0]        tx_ackpol_o,
  output reg               tx_msdu_o,
  output reg  [11:0]       tx_seq_o,
  output reg  [3:0]        tx_frag_o,
  output reg  [15:0]       tx_len_o,
  output reg               tx_end_o,
  input  wire              bk_rx_i,
  input  wire              bk_pay_i,
  input  wire [7:0]        bk_cnt_i,
  input  wire [15:0]       bk_size_i,
  input  wire [11:0]       bk_seq_i,
  input  wire [BMAP_W-1:0] bk_bmap_i,
  input  wire              rx_sub_i,
  input  wire [11:0]       rx_sub_seq_i,
  input  wire              rx_sub_ok_i,
  input  wire              rx_end_i,
  input  wire              rx_agg_i,
  input  wire              rx_areq_i,
  input  wire [1:0]        rx_ackpol_i,
  input  wire              rx_hcs_ok_i,
  output reg               bk_tx_o,
  output reg               bk_tx_pay_o,
  output reg  [7:0]        bk_tx_cnt_o,
  output reg  [15:0]       bk_tx_size_o,
  output reg  [11:0]       bk_tx_seq_o,
  output reg  [BMAP_W-1:0] bk_tx_bmap_o,
  output reg               rel_o
);
  localparam SIFS_CYC = (`SIFS_NS + `CLK_NS - 1) / `CLK_NS;
  localparam S_IDLE = 3'h0;
  localparam S_REQ  = 3'h1;
  localparam S_WAIT = 3'h2;
  localparam S_EVAL = 3'h3;
  localparam S_BLD  = 3'h4;
  localparam S_END  = 3'h5;

  // Held list: a ring in push order, so index order is sequence order.
  reg  [11:0]  h_seq  [0:DEPTH-1];
  reg  [3:0]   h_frag [0:DEPTH-1];
  reg  [15:0]  h_len  [0:DEPTH-1];
  reg  [3:0]   h_did  [0:DEPTH-1];
  reg  [DEPTH-1:0] h_done;
  reg  [AW-1:0] head;
  reg  [AW-1:0] tail;
  reg  [AW:0]   cnt;
  reg  [2:0]    ctrl;
  reg  [3:0]    did;
  reg  [23:0]   rxlim;
  reg           refused;
  reg           ovf;
  reg  [2:0]    state;
  reg  [AW:0]   scan;
  reg  [7:0]    g_cnt;
  reg  [15:0]   g_size;
  reg  [7:0]    n_msdu;
  reg  [16:0]   n_oct;
  reg  [11:0]   a_seq;
  reg  [BMAP_W-1:0] a_bmap;
  reg  [31:0]   wait_cnt;
  reg           sent_one;
  reg  [AW-1:0] sent_idx;

  wire          acc     = cyc_i & stb_i & ~ack_o;
  // Writes land at the edge where the master samples ack high.
  wire          wr      = cyc_i & stb_i & we_i & ack_o;
  wire [AW-1:0] sidx    = head + scan[AW-1:0];
  wire          s_in    = (scan < cnt);
  wire          s_live  = s_in && !h_done[sidx] && (h_did[sidx] == did);
  wire          do_push = wr && (adr_i == `A_PUSH) && (cnt != DEPTH);
  wire          do_pop  = (cnt != 0) && h_done[head] &&
                          (state == S_IDLE || state == S_WAIT);
  wire          m_drop;
  wire          m_acked;
  wire [16:0]   oct_nx  = n_oct + {1'b0, h_len[sidx]};
  // A request frame carries one MSDU at most and leaves the grant untouched.
  wire          fits    = (n_msdu < AGG_LIMIT) && (tx_areq_o ? (n_msdu == 8'h00) :
                          ((n_msdu < g_cnt) && (oct_nx <= {1'b0, g_size})));

  back_match #(
    .BMAP_W (BMAP_W)
  ) u_match (
    .seq_i     (h_seq[sidx]),
    .ack_seq_i (a_seq),
    .bmap_i    (a_bmap),
    .drop_o    (m_drop),
    .acked_o   (m_acked)
  );

  // Register file and bus answer; every access gets a one-cycle ack.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      ctrl  <= `CTRL_RST;
      did   <= `DID_RST;
      rxlim <= `RXLIM_RST;
    end
    else
    begin
      ack_o <= acc;
      dat_o <= 32'h00000000;
      if (wr && sel_i[0] && adr_i == `A_CTRL)
        ctrl <= dat_i[2:0];
      if (wr && sel_i[0] && adr_i == `A_DID)
        did <= dat_i[3:0];
      if (wr && adr_i == `A_RXLIM)
        rxlim <= dat_i[23:0];
      if (acc && !we_i)
      begin
        case (adr_i)
          `A_CTRL:   dat_o <= {29'h00000000, ctrl};
          `A_DID:    dat_o <= {28'h0000000, did};
          `A_STATUS: dat_o <= {16'h0000, 3'h0, refused, ovf, state,
                               {(8-AW-1){1'b0}}, cnt};
          `A_GRANT:  dat_o <= {8'h00, g_size, g_cnt};
          `A_RXLIM:  dat_o <= {8'h00, rxlim};
          default:   dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // Push path: software loads each MSDU descriptor into the held list; a push to a full list only sets ovf.
  always @(posedge clk_i)
  begin
    if (do_push)
    begin
      h_seq[tail]  <= dat_i[11:0];
      h_frag[tail] <= dat_i[15:12];
      h_len[tail]  <= dat_i[31:16];
      h_did[tail]  <= did;
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tail <= {AW{1'b0}};
      head <= {AW{1'b0}};
      cnt  <= {(AW+1){1'b0}};
      ovf  <= 1'b0;
    end
    else
    begin
      if (do_push)
        tail <= tail + 1'b1;
      if (do_pop)
        head <= head + 1'b1;
      cnt <= cnt + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
      if (wr && adr_i == `A_PUSH && cnt == DEPTH)
        ovf <= 1'b1;
      else if (wr && adr_i == `A_CMD && dat_i[`B_START])
        ovf <= 1'b0;
    end
  end

  // Source sequencer: request, wait for the block ack, sort, build.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state       <= S_IDLE;
      h_done      <= {DEPTH{1'b0}};
      refused     <= 1'b0;
      scan        <= {(AW+1){1'b0}};
      g_cnt       <= 8'h00;
      g_size      <= 16'h0000;
      n_msdu      <= 8'h00;
      n_oct       <= 17'h00000;
      a_seq       <= 12'h000;
      a_bmap      <= {BMAP_W{1'b0}};
      wait_cnt    <= 32'h00000000;
      sent_one    <= 1'b0;
      sent_idx    <= {AW{1'b0}};
      tx_start_o  <= 1'b0;
      tx_agg_o    <= 1'b0;
      tx_areq_o   <= 1'b0;
      tx_ackpol_o <= 2'h0;
      tx_msdu_o   <= 1'b0;
      tx_seq_o    <= 12'h000;
      tx_frag_o   <= 4'h0;
      tx_len_o    <= 16'h0000;
      tx_end_o    <= 1'b0;
    end
    else
    begin
      tx_start_o <= 1'b0;
      tx_msdu_o  <= 1'b0;
      tx_end_o   <= 1'b0;
      if (do_push)
        h_done[tail] <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (wr && adr_i == `A_CMD && dat_i[`B_START] && ctrl[`B_EN] &&
              ctrl[`B_PEERCAP])
          begin
            refused <= 1'b0;
            state   <= S_REQ;
          end
        end
        S_REQ:
        begin
          // One frame per stream: carries the oldest live MSDU or none.
          tx_start_o  <= 1'b1;
          tx_agg_o    <= 1'b1;
          tx_areq_o   <= 1'b1;
          tx_ackpol_o <= `POL_BREQ;
          scan        <= {(AW+1){1'b0}};
          sent_one    <= 1'b0;
          n_msdu      <= 8'h00;
          n_oct       <= 17'h00000;
          state       <= S_BLD;
        end
        S_WAIT:
        begin
          wait_cnt <= wait_cnt + 32'h00000001;
          if (bk_rx_i)
          begin
            wait_cnt <= 32'h00000000;
            if (!bk_pay_i)
            begin
              // The request frame counts as delivered.
              if (sent_one)
                h_done[sent_idx] <= 1'b1;
              refused <= 1'b1;
              state   <= S_IDLE;
            end
            else
            begin
              g_cnt  <= bk_cnt_i;
              g_size <= bk_size_i;
              a_seq  <= bk_seq_i;
              a_bmap <= bk_bmap_i;
              scan   <= {(AW+1){1'b0}};
              state  <= S_EVAL;
            end
          end
          else if (wait_cnt == BACK_WAIT_CYC - 1)
          begin
            wait_cnt <= 32'h00000000;
            state    <= S_REQ;
          end
        end
        S_EVAL:
        begin
          if (s_in)
          begin
            if (m_drop || m_acked)
              h_done[sidx] <= 1'b1;
            scan <= scan + 1'b1;
          end
          else
          begin
            scan     <= {(AW+1){1'b0}};
            n_msdu   <= 8'h00;
            n_oct    <= 17'h00000;
            sent_one <= 1'b0;
            // A zero grant sends a fresh request; an unacked one is resent.
            if (g_cnt == 8'h00 || g_size == 16'h0000)
              state <= S_REQ;
            else
            begin
              tx_start_o  <= 1'b1;
              tx_agg_o    <= 1'b1;
              tx_areq_o   <= 1'b0;
              tx_ackpol_o <= `POL_BREQ;
              state       <= S_BLD;
            end
          end
        end
        S_BLD:
        begin
          // Scanning stops at the first misfit so order never inverts.
          if (s_in && (!s_live || fits))
          begin
            scan <= scan + 1'b1;
            if (s_live)
            begin
              tx_msdu_o <= 1'b1;
              tx_seq_o  <= h_seq[sidx];
              tx_frag_o <= h_frag[sidx];
              tx_len_o  <= h_len[sidx];
              n_msdu    <= n_msdu + 8'h01;
              n_oct     <= oct_nx;
              if (tx_areq_o)
              begin
                sent_one <= 1'b1;
                sent_idx <= sidx;
              end
            end
          end
          else
            state <= S_END;
        end
        S_END:
        begin
          tx_end_o <= 1'b1;
          wait_cnt <= 32'h00000000;
          state    <= S_WAIT;
        end
        default:
          state <= S_IDLE;
      endcase
      if (!ctrl[`B_EN])
        state <= S_IDLE;
    end
  end

  // Recipient side: collect subframe results, answer one SIFS later.
  reg  [11:0]       r_base;
  reg               r_first;
  reg  [BMAP_W-1:0] r_bmap;
  reg               r_bad;
  reg               r_pend;
  reg               r_pay;
  reg  [15:0]       r_sifs;
  reg               miss_run;
  reg  [31:0]       miss_cnt;
  wire [11:0]       r_off   = rx_sub_seq_i - r_base;
  wire              r_breq  = rx_end_i && rx_hcs_ok_i && (rx_ackpol_i == `POL_BREQ) &&
                              (rx_agg_i || rx_areq_i);

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r_base       <= 12'h000;
      r_first      <= 1'b1;
      r_bmap       <= {BMAP_W{1'b0}};
      r_bad        <= 1'b0;
      r_pend       <= 1'b0;
      r_pay        <= 1'b0;
      r_sifs       <= 16'h0000;
      miss_run     <= 1'b0;
      miss_cnt     <= 32'h00000000;
      bk_tx_o      <= 1'b0;
      bk_tx_pay_o  <= 1'b0;
      bk_tx_cnt_o  <= 8'h00;
      bk_tx_size_o <= 16'h0000;
      bk_tx_seq_o  <= 12'h000;
      bk_tx_bmap_o <= {BMAP_W{1'b0}};
      rel_o        <= 1'b0;
    end
    else
    begin
      bk_tx_o <= 1'b0;
      rel_o   <= 1'b0;
      if (rx_sub_i)
      begin
        if (r_first)
        begin
          r_base  <= rx_sub_seq_i;
          r_first <= 1'b0;
          r_bmap  <= {{(BMAP_W-1){1'b0}}, rx_sub_ok_i};
        end
        else if (r_off < BMAP_W)
          r_bmap[r_off[3:0]] <= rx_sub_ok_i;
        if (!rx_sub_ok_i)
          r_bad <= 1'b1;
      end
      if (rx_end_i)
        r_first <= 1'b1;
      if (r_breq)
      begin
        r_pend <= 1'b1;
        r_sifs <= 16'h0000;
        r_pay  <= !(rx_areq_i && !rx_agg_i && !ctrl[`B_ACCEPT]);
      end
      else if (r_pend)
      begin
        r_sifs <= r_sifs + 16'h0001;
        if (r_sifs == SIFS_CYC - 1)
        begin
          r_pend       <= 1'b0;
          bk_tx_o      <= 1'b1;
          bk_tx_pay_o  <= r_pay;
          bk_tx_cnt_o  <= r_pay ? rxlim[7:0] : 8'h00;
          bk_tx_size_o <= r_pay ? rxlim[23:8] : 16'h0000;
          bk_tx_seq_o  <= r_pay ? r_base : 12'h000;
          bk_tx_bmap_o <= r_pay ? r_bmap : {BMAP_W{1'b0}};
          r_bad        <= rx_sub_i && !rx_sub_ok_i;
          if (r_bad)
          begin
            miss_run <= 1'b1;
            miss_cnt <= 32'h00000000;
          end
        end
      end
      // Without the timeout a lost subframe would hold buffers forever.
      if (miss_run && !(r_pend && r_sifs == SIFS_CYC - 1))
      begin
        miss_cnt <= miss_cnt + 32'h00000001;
        if (miss_cnt == MISS_TO_CYC - 1)
        begin
          miss_run <= 1'b0;
          rel_o    <= 1'b1;
        end
      end
    end
  end
  // Instances per stream or peer are time-shared: software switches the
  // Delivery ID, and each held entry keeps the ID it was pushed with.
endmodule // msdu_agg_back
`default_nettype wire

// File: testbench/msdu_agg_back_asserts.sv
`timescale 1ns/1ns
`default_nettype none
`include "msdu_agg_consts.vh"
module msdu_agg_back_asserts #(
  parameter AGG_LIMIT = 8
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  input wire logic        tx_start_o,
  input wire logic        tx_agg_o,
  input wire logic        tx_areq_o,
  input wire logic [1:0]  tx_ackpol_o,
  input wire logic        tx_msdu_o,
  input wire logic [11:0] tx_seq_o,
  input wire logic [3:0]  tx_frag_o,
  input wire logic [15:0] tx_len_o,
  input wire logic        bk_rx_i,
  input wire logic        bk_pay_i,
  input wire logic [7:0]  bk_cnt_i,
  input wire logic [15:0] bk_size_i,
  input wire logic        rx_end_i,
  input wire logic        rx_agg_i,
  input wire logic        rx_areq_i,
  input wire logic [1:0]  rx_ackpol_i,
  input wire logic        rx_hcs_ok_i,
  input wire logic        bk_tx_o,
  input wire logic        bk_tx_pay_o,
  input wire logic [7:0]  bk_tx_cnt_o,
  input wire logic [15:0] bk_tx_size_o
);
  logic [3:0]  n_in;
  logic [16:0] sum;
  logic [15:0] last;
  logic        areq_f;
  logic [7:0]  g_cnt;
  logic [15:0] g_size;
  logic [23:0] rxlim;
  wire         ask = rx_end_i && rx_hcs_ok_i && rx_ackpol_i == `POL_BREQ &&
                     (rx_agg_i || rx_areq_i);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // The grant is tracked from the bus and link inputs, so a design that ignores it is caught.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      n_in   <= 4'h0;
      sum    <= 17'h0;
      g_cnt  <= 8'h0;
      g_size <= 16'h0;
      rxlim  <= 24'h0;
    end
    else
    begin
      if (tx_start_o)
      begin
        n_in   <= 4'h0;
        sum    <= 17'h0;
        areq_f <= tx_areq_o;
      end
      if (tx_msdu_o)
      begin
        n_in <= n_in + 4'h1;
        sum  <= sum + {1'b0, tx_len_o};
        last <= {tx_seq_o, tx_frag_o};
      end
      if (bk_rx_i && bk_pay_i)
      begin
        g_cnt  <= bk_cnt_i;
        g_size <= bk_size_i;
      end
      if (cyc_i && stb_i && we_i && ack_o && adr_i == `A_RXLIM)
        rxlim <= dat_i[23:0];
    end
  end
  AST_BUS_ACK: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus ack is not a single pulse one cycle after the request");
  AST_LAYOUT: assert property (tx_start_o |-> tx_agg_o)
    else $error("frame started without aggregated layout");
  AST_REQ_POLICY: assert property (tx_start_o && tx_areq_o |-> tx_ackpol_o == `POL_BREQ)
    else $error("request frame without block ack request policy");
  AST_ORDER: assert property (tx_msdu_o && n_in != 4'h0 |-> {tx_seq_o, tx_frag_o} > last)
    else $error("MSDUs out of order inside one frame");
  AST_AGG_LIMIT: assert property (tx_msdu_o |-> n_in < AGG_LIMIT)
    else $error("more MSDUs than the aggregation limit");
  AST_GRANT_COUNT: assert property (tx_msdu_o && !areq_f |-> n_in < g_cnt)
    else $error("aggregate exceeds granted frame count");
  AST_GRANT_SIZE: assert property (tx_msdu_o && !areq_f |-> sum + tx_len_o <= g_size)
    else $error("aggregate exceeds granted buffer size");
  AST_SIFS_REPLY: assert property (ask |-> ##1 (!bk_tx_o) [*8] ##118 bk_tx_o)
    else $error("block ack not sent one SIFS after the frame");
  AST_AGG_PAYLOAD: assert property (ask && rx_agg_i |-> ##126 bk_tx_pay_o)
    else $error("block ack to an aggregate has no payload");
  AST_BK_LIMITS: assert property (bk_tx_o && bk_tx_pay_o |->
      {bk_tx_size_o, bk_tx_cnt_o} == rxlim)
    else $error("block ack limits differ from the programmed limits");
endmodule // msdu_agg_back_asserts
bind msdu_agg_back msdu_agg_back_asserts #(.AGG_LIMIT(AGG_LIMIT)) u_asserts (.*);
`default_nettype wire

// File: testbench/peer_mac_model.sv
`timescale 1ns/1ns
`default_nettype none
module peer_mac_model (
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  input  wire logic   tx_end_i,
  output logic        bk_rx_o,
  output logic        bk_pay_o,
  output logic [7:0]  bk_cnt_o,
  output logic [15:0] bk_size_o,
  output logic [11:0] bk_seq_o,
  output logic [15:0] bk_bmap_o
);
  // Reply script, one entry per frame end: 0 silent, 1 empty payload, 2 payload.
  logic [1:0]  rmode [0:7];
  logic [7:0]  rcnt [0:7];
  logic [15:0] rsize [0:7];
  logic [11:0] rseq [0:7];
  logic [15:0] rbmap [0:7];
  logic [2:0]  k;
  logic [2:0]  cur;
  logic [3:0]  dly;
  logic        pend;
  logic [15:0] pat = 16'h1234;
  // Outside a reply the fields churn, so a design reading them late sees garbage.
  assign bk_pay_o  = bk_rx_o ? rmode[cur] == 2'h2 : pat[0];
  assign bk_cnt_o  = bk_rx_o ? rcnt[cur] : pat[7:0];
  assign bk_size_o = bk_rx_o ? rsize[cur] : pat;
  assign bk_seq_o  = bk_rx_o ? rseq[cur] : pat[11:0];
  assign bk_bmap_o = bk_rx_o ? rbmap[cur] : ~pat;
  always @(posedge clk_i)
  begin
    pat     <= pat + 16'h5A5B;
    bk_rx_o <= 1'b0;
    if (rst_i)
    begin
      k    <= 3'h0;
      pend <= 1'b0;
    end
    else if (tx_end_i)
    begin
      pend <= 1'b1;
      // Odd replies come late, still inside the source's wait, to model a slow peer.
      dly  <= k[0] ? 4'hE : 4'h1;
    end
    else if (pend && dly != 4'h0)
      dly <= dly - 4'h1;
    else if (pend)
    begin
      pend    <= 1'b0;
      cur     <= k;
      k       <= k + 3'h1;
      bk_rx_o <= rmode[k] != 2'h0;
    end
  end
endmodule // peer_mac_model
`default_nettype wire

// File: testbench/tb_msdu_agg_back.sv
`timescale 1ns/1ns
`default_nettype none
`include "msdu_agg_consts.vh"
module tb_msdu_agg_back;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic        rx_sub_i = 1'b0;
  logic [11:0] rx_sub_seq_i = 12'h000;
  logic        rx_sub_ok_i = 1'b0;
  logic        rx_end_i = 1'b0;
  logic        rx_agg_i = 1'b0;
  logic        rx_areq_i = 1'b0;
  logic [1:0]  rx_ackpol_i = `POL_BREQ;
  logic        rx_hcs_ok_i = 1'b1;
  logic        bk_rx_i, bk_pay_i, bk_tx_o, bk_tx_pay_o, rel_o;
  logic [7:0]  bk_cnt_i, bk_tx_cnt_o;
  logic [15:0] bk_size_i, bk_bmap_i, tx_len_o, bk_tx_size_o, bk_tx_bmap_o;
  logic [11:0] bk_seq_i, tx_seq_o, bk_tx_seq_o;
  logic [31:0] dat_o, rd, sig;
  logic        ack_o, tx_start_o, tx_agg_o, tx_areq_o, tx_msdu_o, tx_end_o;
  logic [1:0]  tx_ackpol_o;
  logic [3:0]  tx_frag_o;
  logic [31:0] frames [0:7];
  logic [7:0]  regs [0:5] = '{`A_CTRL, `A_DID, `A_STATUS, `A_GRANT, `A_RXLIM, 8'h1C};
  logic [31:0] exp_fr [0:5] = '{32'h12, 32'h13, 32'h14, 32'h45, 32'h05, 32'h15};
  int          n_fail = 0;
  int          num_checks = 0;
  int          nfr = 0;
  int          n_rel = 0;
  int          ticks = 0;
  msdu_agg_back #(.BACK_WAIT_CYC(20), .MISS_TO_CYC(30)) dut (.*);
  peer_mac_model peer (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .tx_end_i  (tx_end_o),
    .bk_rx_o   (bk_rx_i),
    .bk_pay_o  (bk_pay_i),
    .bk_cnt_o  (bk_cnt_i),
    .bk_size_o (bk_size_i),
    .bk_seq_o  (bk_seq_i),
    .bk_bmap_o (bk_bmap_i)
  );
  always #10 clk_i = ~clk_i;
  // A frame is logged as its request bit followed by the low nibble of each seq sent.
  always @(posedge clk_i)
  begin
    ticks++;
    if (ticks == 20000)
    begin
      n_fail++;
      final_report();
    end
    if (rel_o === 1'b1)
      n_rel++;
    if (tx_start_o === 1'b1)
      sig = {31'h0, tx_areq_o};
    if (tx_msdu_o === 1'b1)
      sig = {sig[27:0], tx_seq_o[3:0]};
    if (tx_end_o === 1'b1)
    begin
      frames[nfr[2:0]] = sig;
      nfr++;
    end
  end
  task automatic final_report();
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1)
      @(posedge clk_i);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_idle();
    do
      wb(1'b0, `A_STATUS, 32'h0);
    while (rd[10:8] !== 3'h0);
  endtask
  task automatic rx_frame(input logic [11:0] s, input int n, input logic [3:0] ok,
                          input logic agg, input logic areq);
    for (int i = 0; i < n; i++)
    begin
      rx_sub_i     <= 1'b1;
      rx_sub_seq_i <= s + i[11:0];
      rx_sub_ok_i  <= ok[i];
      @(posedge clk_i);
    end
    rx_sub_i  <= 1'b0;
    rx_end_i  <= 1'b1;
    rx_agg_i  <= agg;
    rx_areq_i <= areq;
    @(posedge clk_i);
    rx_end_i <= 1'b0;
    while (bk_tx_o !== 1'b1)
      @(posedge clk_i);
  endtask
  initial
  begin
    peer.rmode = '{2'h1, 2'h2, 2'h2, 2'h2, 2'h0, 2'h1, 2'h0, 2'h0};
    peer.rcnt = '{8'h0, 8'h0, 8'h2, 8'h8, 8'h0, 8'h0, 8'h0, 8'h0};
    peer.rsize = '{16'h0, 16'h80, 16'h1000, 16'h40, 16'h0, 16'h0, 16'h0, 16'h0};
    peer.rseq = '{12'h0, 12'h3, 12'h4, 12'h5, 12'h0, 12'h0, 12'h0, 12'h0};
    peer.rbmap = '{16'h0, 16'h1, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b1, 8'h1C, 32'hFFFFFFFF);
    foreach (regs[i])
    begin
      wb(1'b0, regs[i], 32'h0);
      chk(rd, 32'h0);
    end
    rx_frame(12'h007, 1, 4'h1, 1'b0, 1'b1);
    chk({31'h0, bk_tx_pay_o}, 32'h0);
    wb(1'b1, `A_RXLIM, 32'h00010004);
    wb(1'b1, `A_CTRL, 32'h7);
    rx_frame(12'h008, 3, 4'h5, 1'b1, 1'b0);
    chk({7'h0, bk_tx_pay_o, bk_tx_size_o, bk_tx_cnt_o}, 32'h01010004);
    chk({4'h0, bk_tx_seq_o, bk_tx_bmap_o}, 32'h00080005);
    repeat (200) @(posedge clk_i);
    chk(n_rel, 1);
    rx_frame(12'h00C, 1, 4'h1, 1'b0, 1'b1);
    chk({7'h0, bk_tx_pay_o, bk_tx_size_o, bk_tx_cnt_o}, 32'h01010004);
    chk({4'h0, bk_tx_seq_o, bk_tx_bmap_o}, 32'h000C0001);
    wb(1'b1, `A_CTRL, 32'h1);
    wb(1'b1, `A_CMD, 32'h1);
    repeat (10) @(posedge clk_i);
    chk(nfr, 0);
    wb(1'b1, `A_DID, 32'h2);
    wb(1'b1, `A_PUSH, 32'h00400001);
    wb(1'b1, `A_DID, 32'h1);
    for (int s = 2; s < 7; s++)
      wb(1'b1, `A_PUSH, 32'h00400000 + s);
    wb(1'b1, `A_CTRL, 32'h3);
    repeat (2)
    begin
      wb(1'b1, `A_CMD, 32'h1);
      wait_idle();
      chk(rd & 32'h1700, 32'h1000);
    end
    chk(nfr, 6);
    foreach (exp_fr[i])
      chk(frames[i], exp_fr[i]);
    wb(1'b0, `A_GRANT, 32'h0);
    chk(rd, 32'h00004008);
    final_report();
  end
endmodule // tb_msdu_agg_back
`default_nettype wire
